// ---- dpf_buf_mem.sv ----
// Dual priority packet buffer storage, one write and one registered read port.
// Assumes the caller never reads and writes the same word in one cycle.
`timescale 1ns/1ns
`default_nettype none

module dpf_buf_mem #(
	parameter int unsigned WIDTH = 16,
	parameter int unsigned DEPTH = 32
) (
	input  wire logic                     clk_i,
	input  wire logic                     wr_en_i,
	input  wire logic [$clog2(DEPTH)-1:0] wr_addr_i,
	input  wire logic [WIDTH-1:0]         wr_data_i,
	input  wire logic                     rd_en_i,
	input  wire logic [$clog2(DEPTH)-1:0] rd_addr_i,
	output logic      [WIDTH-1:0]         rd_data_o
);

	logic [WIDTH-1:0] mem_q [DEPTH];

	// Storage has no reset; contents are only read after being written.
	always_ff @(posedge clk_i) begin
		if (wr_en_i) begin
			mem_q[wr_addr_i] <= wr_data_i;
		end
	end

	// Read data is registered so the read is a plain block RAM access.
	always_ff @(posedge clk_i) begin
		if (rd_en_i) begin
			rd_data_o <= mem_q[rd_addr_i];
		end
	end

endmodule : dpf_buf_mem
`default_nettype wire

// ---- dpf_framer.sv ----
// Transmit framer joining a cut-through regular port and a store-and-forward
// priority port onto one link word stream, with oversize policing.
// Assumes feeding logic and the serializer share clk_i; the link takes
// one word every cycle in which link_o.valid is high.
`timescale 1ns/1ns
`default_nettype none

// Operation
// - In packet mode senders mark first word and last word of each packet.
// - Streaming mode drops first, last and empty sideband on the regular side only.
// - Regular streaming may be paused to slip priority packets onto the link.
// - Regular port accepts any packet length; logic does not depend on it.
// - Priority packets are at most 256 bytes, bounded by the buffers.
// - Maximum priority size is a build parameter, 2 to 256, default 32.
// - Each priority buffer holds the configured maximum size, rounded up to whole words.
// - Priority packets from one byte up to the maximum are forwarded.
// - With size testing, oversize packets are dropped and status bit 5 set.
// - Size testing defaults on and then needs maximum as bus width multiple.
// - With size testing, packets shorter than the maximum still pass.
// - Without size testing oversize packets pass truncated and raise no error.
// - A ready priority packet pre-empts regular traffic without losing regular data.
// - A priority packet is sent only once fully stored in a buffer.
module dpf_framer
	import dpf_pkg::*;
#(
	parameter int unsigned MAX_PKT_BYTES = MAX_PKT_DFLT,
	parameter bit          SIZE_TEST     = 1'b1,
	parameter bit          REG_STREAM    = 1'b0
) (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire dpf_word_t   reg_tx_i,
	output logic             reg_ready_o,
	input  wire dpf_word_t   prio_tx_i,
	output logic             prio_ready_o,
	output dpf_link_t        link_o,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	output logic             irq_o
);

	// ==================================================================
	// Buffer geometry
	localparam int unsigned MAX_WORDS = (MAX_PKT_BYTES + DATA_BYTES - 1) / DATA_BYTES;
	localparam int unsigned DEPTH     = 2 * MAX_WORDS;
	localparam int unsigned AW        = $clog2(DEPTH);
	localparam int unsigned CW        = $clog2(MAX_WORDS + 1);
	localparam int unsigned MW        = 2 + EMPTY_W + DATA_W;
	localparam logic [CW-1:0] MAX_WORDS_C = CW'(MAX_WORDS);
	localparam logic [EMPTY_W-1:0] TRUNC_EMPTY =
		EMPTY_W'(MAX_WORDS * DATA_BYTES - MAX_PKT_BYTES);

	// Build-time checks on the size choice.
	generate
		if (MAX_PKT_BYTES < MAX_PKT_MIN || MAX_PKT_BYTES > MAX_PKT_LIM) begin : g_bad_range
			$error("Maximum priority packet size out of range.");
		end
		if (SIZE_TEST && (MAX_PKT_BYTES % DATA_BYTES) != 0) begin : g_bad_mult
			$error("Size testing needs a maximum that is a bus width multiple.");
		end
	endgenerate

	// Word address of a word inside one of the two buffers.
	function automatic logic [AW-1:0] buf_addr(input logic b, input logic [CW-1:0] idx);
		buf_addr = AW'((b ? MAX_WORDS : 0) + int'(idx));
	endfunction : buf_addr

	// ==================================================================
	// State declarations
	logic              link_en;
	logic [0:0]        ctrl_q;
	logic [5:0]        status_q, status_d, mask_q;
	logic [1:0]        full_q, full_d;
	logic [CW-1:0]     len_q [2];
	logic [EMPTY_W-1:0] lempty_q [2];
	logic              wr_buf_q, wr_buf_d;
	logic [CW-1:0]     wr_cnt_q;
	logic              wr_inpkt_q, wr_drop_q;
	logic              prio_take, wr_start, wr_fits, wr_en, wr_done, wr_bad;
	logic [CW-1:0]     wr_idx;
	dpf_rd_state_t     rd_state_q, rd_state_d;
	logic              rd_buf_q, rd_buf_d;
	logic [CW-1:0]     rd_cnt_q, rd_idx;
	logic              rd_issue, rd_final;
	logic              pend_q, pend_first_q, pend_last_q;
	logic [EMPTY_W-1:0] pend_empty_q;
	logic [DATA_W-1:0] mem_rd;
	logic              reg_take;
	logic              ev_prio, ev_reg, ev_over;

	assign link_en = ctrl_q[0];

	// ==================================================================
	// Priority write side: store each delimited packet into a free buffer.
	assign prio_take = prio_tx_i.valid && prio_ready_o;
	assign wr_start  = prio_take && prio_tx_i.first;
	assign wr_idx    = wr_start ? '0 : wr_cnt_q;
	assign wr_fits   = wr_idx < MAX_WORDS_C;
	assign wr_en     = prio_take && (wr_inpkt_q || wr_start) && wr_fits && !wr_bad;
	assign wr_bad    = SIZE_TEST && ((wr_drop_q && !wr_start) || !wr_fits);
	assign wr_done   = prio_take && (wr_inpkt_q || wr_start) && prio_tx_i.last;

	// Words outside a framed packet are ignored, as the port has no stream mode.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wr_cnt_q   <= '0;
			wr_inpkt_q <= 1'b0;
			wr_drop_q  <= 1'b0;
		end else if (prio_take && (wr_inpkt_q || wr_start)) begin
			wr_inpkt_q <= !prio_tx_i.last;
			wr_drop_q  <= wr_bad && !prio_tx_i.last;
			if (wr_fits) begin
				wr_cnt_q <= wr_idx + CW'(1);
			end
		end
	end

	// Length and trailing empty count of each finished packet.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			len_q[0]    <= '0;
			len_q[1]    <= '0;
			lempty_q[0] <= '0;
			lempty_q[1] <= '0;
		end else if (wr_done && !wr_bad) begin
			len_q[wr_buf_q]    <= wr_fits ? wr_idx + CW'(1) : MAX_WORDS_C;
			lempty_q[wr_buf_q] <= wr_fits ? prio_tx_i.empty : TRUNC_EMPTY;
		end
	end

	// ==================================================================
	// Buffer ownership; a set by the writer and a clear by the reader
	// always touch different buffers, so neither can mask the other.
	always_comb begin
		full_d   = full_q;
		wr_buf_d = wr_buf_q;
		rd_buf_d = rd_buf_q;
		if (rd_final) begin
			full_d[rd_buf_q] = 1'b0;
			rd_buf_d         = !rd_buf_q;
		end
		if (wr_done && !wr_bad) begin
			full_d[wr_buf_q] = 1'b1;
			wr_buf_d         = !wr_buf_q;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			full_q   <= '0;
			wr_buf_q <= 1'b0;
			rd_buf_q <= 1'b0;
		end else begin
			full_q   <= full_d;
			wr_buf_q <= wr_buf_d;
			rd_buf_q <= rd_buf_d;
		end
	end

	// ==================================================================
	// Priority read side: stream a full buffer onto the link.
	assign rd_issue = (rd_state_q == RD_SEND) ||
		(rd_state_q == RD_IDLE && full_q[rd_buf_q] && link_en);
	assign rd_idx   = (rd_state_q == RD_SEND) ? rd_cnt_q : '0;
	assign rd_final = rd_issue && (rd_idx + CW'(1) >= len_q[rd_buf_q]);

	always_comb begin
		rd_state_d = rd_state_q;
		case (rd_state_q)
			RD_IDLE: begin
				if (rd_issue && !rd_final) begin
					rd_state_d = RD_SEND;
				end
			end
			RD_SEND: begin
				if (rd_final) begin
					rd_state_d = RD_IDLE;
				end
			end
			default: rd_state_d = RD_IDLE;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rd_state_q <= RD_IDLE;
			rd_cnt_q   <= '0;
		end else begin
			rd_state_q <= rd_state_d;
			rd_cnt_q   <= rd_final ? '0 : (rd_issue ? rd_idx + CW'(1) : rd_cnt_q);
		end
	end

	// Framing of the word whose data the memory returns next cycle.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pend_q       <= 1'b0;
			pend_first_q <= 1'b0;
			pend_last_q  <= 1'b0;
			pend_empty_q <= '0;
		end else begin
			pend_q       <= rd_issue;
			pend_first_q <= rd_issue && (rd_idx == '0);
			pend_last_q  <= rd_final;
			pend_empty_q <= rd_final ? lempty_q[rd_buf_q] : '0;
		end
	end

	dpf_buf_mem #(
		.WIDTH (DATA_W),
		.DEPTH (DEPTH)
	) u_mem (
		.clk_i     (clk_i),
		.wr_en_i   (wr_en),
		.wr_addr_i (buf_addr(wr_buf_q, wr_idx)),
		.wr_data_i (prio_tx_i.data),
		.rd_en_i   (rd_issue),
		.rd_addr_i (buf_addr(rd_buf_q, rd_idx)),
		.rd_data_o (mem_rd)
	);

	// ==================================================================
	// Ready flags, computed from next state so they never lag a buffer swap.
	// Regular ready also stays low in the cycle after the final priority read, so a
	// regular word can never land on the same link slot as priority data.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			prio_ready_o <= 1'b0;
			reg_ready_o  <= 1'b0;
		end else begin
			prio_ready_o <= !full_d[wr_buf_d];
			reg_ready_o  <= link_en && rd_state_d == RD_IDLE && !full_d[rd_buf_d] &&
				!rd_issue;
		end
	end

	// ==================================================================
	// Link word register; priority wins, regular data is held off by ready.
	assign reg_take = reg_tx_i.valid && reg_ready_o;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			link_o <= '0;
		end else if (pend_q) begin
			link_o <= '{valid: 1'b1, prio: 1'b1, first: pend_first_q, last: pend_last_q,
				empty: pend_empty_q, data: mem_rd};
		end else if (reg_take) begin
			link_o.valid <= 1'b1;
			link_o.prio  <= 1'b0;
			link_o.first <= REG_STREAM ? 1'b0 : reg_tx_i.first;
			link_o.last  <= REG_STREAM ? 1'b0 : reg_tx_i.last;
			link_o.empty <= REG_STREAM ? '0 : reg_tx_i.empty;
			link_o.data  <= reg_tx_i.data;
		end else begin
			link_o <= '0;
		end
	end

	// ==================================================================
	// Events and sticky status; a new event beats a write-one clear.
	assign ev_prio = rd_final;
	assign ev_reg  = reg_take && !REG_STREAM && reg_tx_i.last;
	assign ev_over = wr_done && wr_bad;

	always_comb begin
		status_d = status_q;
		if (wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_adr_i == ADDR_STATUS &&
			wb_sel_i[0]) begin
			status_d = status_q & ~(wb_dat_i[5:0] & STATUS_USED);
		end
		if (ev_prio) status_d[ST_PRIO_SENT] = 1'b1;
		if (ev_reg) status_d[ST_REG_END] = 1'b1;
		if (ev_over) status_d[ST_OVERSIZE] = 1'b1;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			status_q <= '0;
			irq_o    <= 1'b0;
		end else begin
			status_q <= status_d;
			irq_o    <= |(status_d & mask_q);
		end
	end

	// ==================================================================
	// Wishbone slave: one-cycle registered ack, unmapped reads give zero.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_q <= CTRL_RESET;
			mask_q <= MASK_RESET;
		end else if (wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0]) begin
			if (wb_adr_i == ADDR_CTRL) begin
				ctrl_q[0] <= wb_dat_i[CTRL_LINK_EN];
			end else if (wb_adr_i == ADDR_MASK) begin
				mask_q <= wb_dat_i[5:0] & STATUS_USED;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= '0;
		end else begin
			wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
			wb_dat_o <= '0;
			if (wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o) begin
				if (wb_adr_i == ADDR_CTRL) begin
					wb_dat_o <= {31'h0, ctrl_q};
				end else if (wb_adr_i == ADDR_STATUS) begin
					wb_dat_o <= {26'h0, status_q};
				end else if (wb_adr_i == ADDR_MASK) begin
					wb_dat_o <= {26'h0, mask_q};
				end else if (wb_adr_i == ADDR_INFO) begin
					wb_dat_o <= {27'h0, rd_buf_q, wr_buf_q, rd_state_q == RD_SEND, full_q};
				end
			end
		end
	end

endmodule : dpf_framer
`default_nettype wire

// ---- dpf_framer_checker.sv ----
// Port checker for the framer: bus timing, link framing, priority bursts.
// Assumes one clock and a synchronous active high reset.
`timescale 1ns/1ns
`default_nettype none
module dpf_framer_checker
	import dpf_pkg::*;
#(
	parameter int unsigned MAX_PKT_BYTES = MAX_PKT_DFLT,
	parameter bit          REG_STREAM    = 1'b0
) (
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire dpf_word_t   reg_tx_i,
	input wire logic        reg_ready_o,
	input wire logic        prio_ready_o,
	input wire dpf_link_t   link_o,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [7:0]  wb_adr_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o
);
	// ==================================================================
	// Helpers
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	wire logic rtake = reg_tx_i.valid && reg_ready_o;
	wire logic pword = link_o.valid && link_o.prio;
	logic [8:0] plen_q;
	// Counts words of the priority burst on the link; a burst past a buffer is a fault.
	always_ff @(posedge clk_i) begin
		if (rst_i || (pword && link_o.last))
			plen_q <= 9'h000;
		else if (pword)
			plen_q <= plen_q + 9'h001;
	end
	// ==================================================================
	// Assertions
	a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("bus request not acked next cycle");
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	a_unmapped_zero: assert property (wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o
		&& wb_adr_i > 8'h0c |=> wb_dat_o == 32'h0) else $error("unmapped read not zero");
	a_reg_forward: assert property (rtake |=> link_o.valid && !link_o.prio
		&& link_o.data == $past(reg_tx_i.data)) else $error("regular word not forwarded");
	a_reg_marks: assert property (rtake |=> link_o.first == (!REG_STREAM && $past(reg_tx_i.first))
		&& link_o.last == (!REG_STREAM && $past(reg_tx_i.last))
		&& link_o.empty == (REG_STREAM ? '0 : $past(reg_tx_i.empty)))
		else $error("regular packet marks wrong");
	// Regular words are held off, not dropped, while a priority burst is still running.
	a_reg_holdoff: assert property (pword && !link_o.last |-> !reg_ready_o)
		else $error("regular port ready inside a priority burst");
	a_prio_burst: assert property (pword && !link_o.last |=> pword)
		else $error("priority burst broken");
	a_prio_fits: assert property (pword |-> plen_q < 9'((MAX_PKT_BYTES + DATA_BYTES - 1) / DATA_BYTES))
		else $error("priority burst longer than buffer");
	a_ready_release: assert property ($fell(rst_i) |=> reg_ready_o && prio_ready_o)
		else $error("ports not ready after reset");
	cover property (pword && link_o.first);
	cover property (rtake && reg_tx_i.last);
	cover property ($rose(wb_ack_o) && !wb_we_i);
	cover property (pword && link_o.last ##1 (link_o.valid && !link_o.prio));
endmodule : dpf_framer_checker
bind dpf_framer dpf_framer_checker #(.MAX_PKT_BYTES(MAX_PKT_BYTES), .REG_STREAM(REG_STREAM)) u_chk (
	.clk_i(clk_i), .rst_i(rst_i), .reg_tx_i(reg_tx_i), .reg_ready_o(reg_ready_o),
	.prio_ready_o(prio_ready_o), .link_o(link_o), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
	.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));
`default_nettype wire

// ---- dpf_pkg.sv ----
// Shared constants and carrier types for the data port framer.
// Assumes one clock domain and a 32-bit classic Wishbone register slave.
package dpf_pkg;

	// ==================================================================
	// Data path shape
	localparam int unsigned DATA_BYTES   = 2;
	localparam int unsigned DATA_W       = DATA_BYTES * 8;
	localparam int unsigned EMPTY_W      = 1;
	localparam int unsigned MAX_PKT_LIM  = 256;
	localparam int unsigned MAX_PKT_MIN  = 2;
	localparam int unsigned MAX_PKT_DFLT = 32;

	// ==================================================================
	// Register map, byte addresses
	localparam logic [7:0] ADDR_CTRL   = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_MASK   = 8'h08;
	localparam logic [7:0] ADDR_INFO   = 8'h0c;

	// ==================================================================
	// Field positions and reset values
	localparam int unsigned CTRL_LINK_EN   = 0;
	localparam int unsigned ST_PRIO_SENT   = 0;
	localparam int unsigned ST_REG_END     = 1;
	localparam int unsigned ST_OVERSIZE    = 5;
	localparam logic [5:0]  STATUS_USED    = 6'h23;
	localparam logic [0:0]  CTRL_RESET     = 1'h1;
	localparam logic [5:0]  MASK_RESET     = 6'h00;
	localparam int unsigned INFO_FULL_LSB  = 0;
	localparam int unsigned INFO_SEND_BIT  = 2;
	localparam int unsigned INFO_WRBUF_BIT = 3;
	localparam int unsigned INFO_RDBUF_BIT = 4;

	// ==================================================================
	// Carrier types
	typedef struct packed {
		logic               valid;
		logic               first;
		logic               last;
		logic [EMPTY_W-1:0] empty;
		logic [DATA_W-1:0]  data;
	} dpf_word_t;

	typedef struct packed {
		logic               valid;
		logic               prio;
		logic               first;
		logic               last;
		logic [EMPTY_W-1:0] empty;
		logic [DATA_W-1:0]  data;
	} dpf_link_t;

	typedef enum logic [0:0] {
		RD_IDLE = 1'b0,
		RD_SEND = 1'b1
	} dpf_rd_state_t;

endpackage : dpf_pkg

// ---- dpf_sys_model.sv ----
// System logic model feeding the regular and priority ports of the framer.
// Assumes it shares clk_i and sees each ready as a registered level.
`timescale 1ns/1ns
`default_nettype none
module dpf_sys_model
	import dpf_pkg::*;
(
	input  wire logic     clk_i,
	input  wire logic     reg_ready_i,
	input  wire logic     prio_ready_i,
	output var dpf_word_t reg_o,
	output var dpf_word_t prio_o
);
	// ==================================================================
	// Word source
	int n_stuck = 0;
	initial begin
		reg_o = '0;
		prio_o = '0;
	end
	// Sends n words marked by b and holds each one until the port takes it.
	task automatic send(input bit pr, input int n, input logic e, input logic [7:0] b);
		dpf_word_t w;
		int t;
		for (int i = 0; i < n; i++) begin
			w = {1'b1, i == 0, i == n - 1, e && i == n - 1, b, 8'(i)};
			if (pr)
				prio_o <= w;
			else
				reg_o <= w;
			t = 0;
			do begin
				@(posedge clk_i);
				t++;
			end while (!(pr ? prio_ready_i : reg_ready_i) && t < 400);
			if (t >= 400)
				n_stuck++;
		end
		// Released data is inverted so a stale word can never pass for a new one.
		w.valid = 1'b0;
		w.data = ~w.data;
		if (pr)
			prio_o <= w;
		else
			reg_o <= w;
		// One idle edge, so a following call never drives the port twice in one step.
		@(posedge clk_i);
	endtask : send
endmodule : dpf_sys_model
`default_nettype wire

// ---- tb_top.sv ----
// Self-checking bench: registers, both data ports, oversize drop, nesting.
// Assumes the system model drives the ports and the checker is bound.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	import dpf_pkg::*;
	// ==================================================================
	// Signals and instances
	localparam int MAXW = 4;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
	logic [7:0] wb_adr = 8'h00;
	logic [3:0] wb_sel = 4'h0;
	logic [31:0] wb_dwr = 32'h0;
	wire logic [31:0] wb_drd;
	wire logic wb_ack, irq, reg_ready, prio_ready;
	wire dpf_word_t reg_tx, prio_tx;
	wire dpf_link_t link, link_s;
	int n_errors = 0;
	int cmp_count = 0;
	dpf_link_t rq[$], pq[$], sq[$], tq[$];
	always #50 clk_i = ~clk_i;
	dpf_framer #(.MAX_PKT_BYTES(MAXW * 2)) u_dut (
		.clk_i(clk_i), .rst_i(rst_i), .reg_tx_i(reg_tx), .reg_ready_o(reg_ready),
		.prio_tx_i(prio_tx), .prio_ready_o(prio_ready), .link_o(link), .wb_cyc_i(wb_cyc),
		.wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
		.wb_dat_i(wb_dwr), .wb_dat_o(wb_drd), .wb_ack_o(wb_ack), .irq_o(irq));
	// Streaming build without size testing; its readies track u_dut's, so it shares the words.
	dpf_framer #(.MAX_PKT_BYTES(MAXW * 2), .SIZE_TEST(1'b0), .REG_STREAM(1'b1)) u_dut_s (
		.clk_i(clk_i), .rst_i(rst_i), .reg_tx_i(reg_tx), .reg_ready_o(),
		.prio_tx_i(prio_tx), .prio_ready_o(), .link_o(link_s), .wb_cyc_i(wb_cyc),
		.wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
		.wb_dat_i(wb_dwr), .wb_dat_o(), .wb_ack_o(), .irq_o());
	dpf_sys_model u_sys (.clk_i(clk_i), .reg_ready_i(reg_ready),
		.prio_ready_i(prio_ready), .reg_o(reg_tx), .prio_o(prio_tx));
	// Link words are split by port so nesting cannot hide a lost word.
	always @(posedge clk_i) begin
		if (link.valid && link.prio)
			pq.push_back(link);
		else if (link.valid)
			rq.push_back(link);
		if (link_s.valid && link_s.prio)
			tq.push_back(link_s);
		else if (link_s.valid)
			sq.push_back(link_s);
	end
	// ==================================================================
	// Tasks
	task automatic complete_run();
		$display("compares %0d errors %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : complete_run
	task automatic hang();
		n_errors++;
		complete_run();
	endtask : hang
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			$display("unexpected %s: expected %h seen %h", nm, e, g);
			n_errors++;
		end
	endtask : chk
	// One classic bus cycle; the request stands until ack is sampled high.
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
			input logic [3:0] s, output logic [31:0] q);
		int t;
		@(posedge clk_i);
		{wb_cyc, wb_stb, wb_we, wb_adr, wb_sel, wb_dwr} <= {2'b11, w, a, s, d};
		t = 0;
		do begin
			@(posedge clk_i);
			t++;
		end while (wb_ack !== 1'b1 && t < 50);
		q = wb_drd;
		{wb_cyc, wb_stb} <= 2'b00;
		if (t >= 50)
			hang();
	endtask : wb
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		logic [31:0] q;
		wb(1'b1, a, d, s, q);
	endtask : wr
	task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
		logic [31:0] q;
		wb(1'b0, a, 32'h0, 4'hf, q);
		chk(nm, e, q);
	endtask : rdc
	// Waits for one packet of one port, then checks every word of it.
	// The streaming build is checked too; with tr set only its priority words are checked.
	task automatic expect_pkt(input bit pr, input int n, input logic e, input logic [7:0] b,
			input bit tr = 1'b0);
		dpf_link_t x, y;
		int t;
		for (t = 0; t < 300 && (tr ? tq.size() < n : ((pr ? pq.size() : rq.size()) < n
				|| (pr ? tq.size() : sq.size()) < n)); t++)
			@(posedge clk_i);
		if (t >= 300)
			hang();
		for (int i = 0; i < n; i++) begin
			y = {1'b1, pr, i == 0, i == n - 1, e && i == n - 1, b, 8'(i)};
			if (!tr) begin
				x = pr ? pq.pop_front() : rq.pop_front();
				chk("link word", 32'(y), 32'(x));
			end
			x = pr ? tq.pop_front() : sq.pop_front();
			if (!pr)
				y[18:16] = 3'b000;
			chk("streaming build word", 32'(y), 32'(x));
		end
	endtask : expect_pkt
	// ==================================================================
	// Sequence
	initial begin
		logic [31:0] q;
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		// Reset values, a refused address and a write with lane 0 off.
		rdc("ctrl", ADDR_CTRL, 32'(CTRL_RESET));
		rdc("status", ADDR_STATUS, 32'h0);
		rdc("mask", ADDR_MASK, 32'(MASK_RESET));
		wr(8'h10, 32'hff, 4'hf);
		rdc("unmapped", 8'h10, 32'h0);
		wr(ADDR_CTRL, 32'h0, 4'he);
		rdc("ctrl lane", ADDR_CTRL, 32'h1);
		wr(ADDR_CTRL, 32'h0, 4'h1);
		@(posedge clk_i);
		chk("ready off", 32'h0, 32'(reg_ready));
		wr(ADDR_CTRL, 32'h1, 4'h1);
		// A regular packet, then priority packets from one byte to the maximum.
		u_sys.send(1'b0, 3, 1'b1, 8'ha1);
		expect_pkt(1'b0, 3, 1'b1, 8'ha1);
		for (int n = 1; n <= MAXW; n++) begin
			u_sys.send(1'b1, n, n == 1, 8'(n));
			expect_pkt(1'b1, n, n == 1, 8'(n));
		end
		rdc("status sent", ADDR_STATUS, 32'h3);
		wr(ADDR_STATUS, 32'h3, 4'h1);
		rdc("status clear", ADDR_STATUS, 32'h0);
		// Oversize packet is dropped whole; the flag interrupts only when unmasked.
		u_sys.send(1'b1, MAXW + 1, 1'b0, 8'hc0);
		for (int k = 0; k < 8 && q[5] !== 1'b1; k++)
			wb(1'b0, ADDR_STATUS, 32'h0, 4'hf, q);
		chk("oversize flag", 32'h20, q);
		chk("dropped words", 32'h0, 32'(pq.size()));
		expect_pkt(1'b1, MAXW, 1'b0, 8'hc0, 1'b1);
		chk("irq masked", 32'h0, 32'(irq));
		wr(ADDR_MASK, 32'h20, 4'h1);
		@(posedge clk_i);
		chk("irq on", 32'h1, 32'(irq));
		wr(ADDR_STATUS, 32'h20, 4'h1);
		@(posedge clk_i);
		chk("irq off", 32'h0, 32'(irq));
		// A long payload split in two fills both buffers back to back.
		u_sys.send(1'b1, MAXW, 1'b0, 8'hd0);
		u_sys.send(1'b1, 2, 1'b0, 8'hd1);
		expect_pkt(1'b1, MAXW, 1'b0, 8'hd0);
		expect_pkt(1'b1, 2, 1'b0, 8'hd1);
		// A priority packet nests inside a long regular packet.
		fork
			u_sys.send(1'b0, 12, 1'b0, 8'he0);
			begin
				repeat (3) @(posedge clk_i);
				u_sys.send(1'b1, 3, 1'b1, 8'he1);
			end
		join
		expect_pkt(1'b1, 3, 1'b1, 8'he1);
		expect_pkt(1'b0, 12, 1'b0, 8'he0);
		chk("stalled sends", 32'h0, 32'(u_sys.n_stuck));
		complete_run();
	end
endmodule : tb_top
`default_nettype wire
